//--- include/brovi_pkg.sv
// Package with formats, limits, sources and register offsets for the reference offset block.
package brovi_pkg;

    // ----------------------------------------------------------------
    // Register map (word addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] BROVI_ADDR_CTRL = 4'h0;
    localparam logic [3:0] BROVI_ADDR_VERT = 4'h1;
    localparam logic [3:0] BROVI_ADDR_COARSE = 4'h2;
    localparam logic [3:0] BROVI_ADDR_FINE = 4'h3;
    localparam logic [3:0] BROVI_ADDR_TC_CFG = 4'h4;
    localparam logic [3:0] BROVI_ADDR_TC_OFS = 4'h5;
    localparam logic [3:0] BROVI_ADDR_STEP = 4'h6;
    localparam logic [3:0] BROVI_ADDR_LTC_MEAS = 4'h7;
    localparam logic [3:0] BROVI_ADDR_STATUS = 4'h8;
    localparam logic [3:0] BROVI_ADDR_TC_SRC = 4'h9;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BROVI_CTRL_ZERO_BIT = 8;
    localparam int BROVI_TC_DROP_BIT = 0;
    localparam int BROVI_TC_S1EN_BIT = 1;
    localparam int BROVI_TC_S2EN_BIT = 2;
    localparam int BROVI_TC_SRC_LSB = 4;
    localparam int BROVI_TC_L1_LSB = 8;
    localparam int BROVI_TC_L2_LSB = 16;
    localparam int BROVI_STEP_FINE_LSB = 16;

    // ----------------------------------------------------------------
    // Output formats
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        BROVI_FMT_525 = 4'h0, BROVI_FMT_625 = 4'h1,
        BROVI_FMT_1080_60 = 4'h2, BROVI_FMT_1080_5994 = 4'h3,
        BROVI_FMT_1080_50 = 4'h4, BROVI_FMT_1080_24 = 4'h5,
        BROVI_FMT_1080_2398 = 4'h6, BROVI_FMT_720_60 = 4'h7,
        BROVI_FMT_720_5994 = 4'h8, BROVI_FMT_720_50 = 4'h9
    } brovi_fmt_e;

    // Timecode sources; disabled is the power-up choice.
    typedef enum logic [2:0] {
        BROVI_SRC_DISABLED = 3'h0,
        BROVI_SRC_LOCAL_TIME_WITH_DAYLIGHT = 3'h1,
        BROVI_SRC_LOCAL_TIME_NO_DAYLIGHT = 3'h2,
        BROVI_SRC_UTC = 3'h3,
        BROVI_SRC_PROGRAM = 3'h4
    } brovi_src_e;

    // ----------------------------------------------------------------
    // Limits in lines, 0.1 ns (coarse) and 0.01 ns (fine); coarse values are rounded to the nearest 0.1 ns.
    // ----------------------------------------------------------------
    localparam logic [10:0] BROVI_VLIM_525 = 11'd525;
    localparam logic [10:0] BROVI_VLIM_625 = 11'd1250;
    localparam logic [10:0] BROVI_VLIM_1080 = 11'd562;
    localparam logic [10:0] BROVI_VLIM_720 = 11'd375;
    localparam logic [19:0] BROVI_HLIM_525 = 20'd635556;
    localparam logic [19:0] BROVI_HLIM_625 = 20'd640000;
    localparam logic [19:0] BROVI_HLIM_1080_60 = 20'd296296;
    localparam logic [19:0] BROVI_HLIM_1080_5994 = 20'd296593;
    localparam logic [19:0] BROVI_HLIM_1080_50 = 20'd355556;
    localparam logic [19:0] BROVI_HLIM_1080_24 = 20'd370370;
    localparam logic [19:0] BROVI_HLIM_1080_2398 = 20'd370741;
    localparam logic [19:0] BROVI_HLIM_720_60 = 20'd222222;
    localparam logic [19:0] BROVI_HLIM_720_5994 = 20'd222444;
    localparam logic [19:0] BROVI_HLIM_720_50 = 20'd266667;
    // Fine limit in units of 0.01 ns: 10.00 ns.
    localparam logic [11:0] BROVI_FLIM = 12'd1000;

    // Timecode insertion line windows and reset lines.
    localparam logic [4:0] BROVI_L525_MIN = 5'd10;
    localparam logic [4:0] BROVI_L525_MAX = 5'd20;
    localparam logic [4:0] BROVI_L625_MIN = 5'd6;
    localparam logic [4:0] BROVI_L625_MAX = 5'd22;
    localparam logic [4:0] BROVI_L1_RST = 5'd14;
    localparam logic [4:0] BROVI_L2_RST = 5'd16;

    // Timecode offset field maxima.
    localparam logic [4:0] BROVI_TC_HMAX = 5'd23;
    localparam logic [5:0] BROVI_TC_MSMAX = 6'd59;
    localparam logic [4:0] BROVI_TC_F30MAX = 5'd29;
    localparam logic [4:0] BROVI_TC_F25MAX = 5'd24;

endpackage

//--- core/brovi_limit_rom.sv
// Registered limit table: offset ranges of the selected output format.
`timescale 1ns/1ps
`default_nettype none
module brovi_limit_rom
    import brovi_pkg::*;
(
    input wire logic core_clk,
    input wire brovi_fmt_e fmt,
    output logic [10:0] vlim,
    output logic [19:0] hlim
);

    // ----------------------------------------------------------------
    // Lookup
    // ----------------------------------------------------------------
    logic [10:0] vlim_next;
    logic [19:0] hlim_next;

    // Vertical span follows the raster; coarse span follows raster and rate.
    always_comb
    begin
        unique case (fmt)
            BROVI_FMT_525: vlim_next = BROVI_VLIM_525;
            BROVI_FMT_625: vlim_next = BROVI_VLIM_625;
            BROVI_FMT_1080_60, BROVI_FMT_1080_5994, BROVI_FMT_1080_50, BROVI_FMT_1080_24,
            BROVI_FMT_1080_2398: vlim_next = BROVI_VLIM_1080;
            BROVI_FMT_720_60, BROVI_FMT_720_5994, BROVI_FMT_720_50:
                vlim_next = BROVI_VLIM_720;
            default: vlim_next = BROVI_VLIM_525;
        endcase
        unique case (fmt)
            BROVI_FMT_525: hlim_next = BROVI_HLIM_525;
            BROVI_FMT_625: hlim_next = BROVI_HLIM_625;
            BROVI_FMT_1080_60: hlim_next = BROVI_HLIM_1080_60;
            BROVI_FMT_1080_5994: hlim_next = BROVI_HLIM_1080_5994;
            BROVI_FMT_1080_50: hlim_next = BROVI_HLIM_1080_50;
            BROVI_FMT_1080_24: hlim_next = BROVI_HLIM_1080_24;
            BROVI_FMT_1080_2398: hlim_next = BROVI_HLIM_1080_2398;
            BROVI_FMT_720_60: hlim_next = BROVI_HLIM_720_60;
            BROVI_FMT_720_5994: hlim_next = BROVI_HLIM_720_5994;
            BROVI_FMT_720_50: hlim_next = BROVI_HLIM_720_50;
            default: hlim_next = BROVI_HLIM_525;
        endcase
    end

    // Registered output keeps the clamp path short.
    always_ff @(posedge core_clk)
    begin
        vlim <= vlim_next;
        hlim <= hlim_next;
    end

endmodule
`default_nettype wire

//--- core/brovi_top.sv
// Offset and timecode insertion configuration for one reference output.
//
// Summary of operation
// - Offsets are taken against the internal reference only.
// - Vertical offset is signed and moves in steps of one line.
// - Vertical and coarse spans follow the selected output format; the fine span is fixed and coarse/fine step sizes are only stored.
// - 525-line: +-525 lines, +-63.5556 us coarse.
// - 625-line: +-1250 lines, +-64.0000 us coarse.
// - 1080-line: +-562 lines, coarse limit set by frame rate.
// - 720-line: +-375 lines, coarse limit set by frame rate.
// - One zeroing request clears vertical, coarse and fine offsets together.
// - Measured timecode timing is reported so frame misalignment is visible.
// - Timecode is inserted only on standard-definition formats.
// - Source is one of five choices; reset choice is disabled.
// - Timecode is emitted only with a source and an enabled slot.
// - Signed offset up to 23:59:59:29 held for read-back, not added; frame maximum is 29 on 525-line, 24 on every other format.
// - Drop-frame counting is selectable and exists only for 525-line formats.
// - Two insertion slots, each with its own enable and line number.
// - 525-line insertion line is 10 to 20.
// - 625-line insertion line is 6 to 22.
// - Reset: offsets zero, slots and source off, drop-frame on.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module brovi_top
    import brovi_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] ref_line,
    input wire logic ref_line_start,
    input wire logic [31:0] src_tc_local_time_with_daylight,
    input wire logic [31:0] src_tc_local,
    input wire logic [31:0] src_tc_utc,
    input wire logic [31:0] src_tc_program,
    input wire logic [19:0] ltc_meas,
    output logic [31:0] reg_rdata,
    output logic signed [11:0] vert_ofs,
    output logic signed [20:0] coarse_ofs,
    output logic signed [12:0] fine_ofs,
    output logic timecode_slot_one,
    output logic timecode_slot_two,
    output logic vitc_active,
    output logic [31:0] vitc_word,
    output logic drop_frame
);

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    brovi_fmt_e fmt_reg;
    logic signed [11:0] vert_reg;
    logic signed [20:0] coarse_reg;
    logic signed [12:0] fine_reg;
    logic [2:0] src_reg;
    logic drop_reg;
    logic s1_en_reg;
    logic s2_en_reg;
    logic [4:0] l1_reg;
    logic [4:0] l2_reg;
    logic tc_neg_reg;
    logic [22:0] tc_ofs_reg;
    logic [15:0] coarse_step_reg;
    logic [15:0] fine_step_reg;
    logic [10:0] vlim;
    logic [19:0] hlim;

    brovi_limit_rom u_lim (
        .core_clk(core_clk),
        .fmt(fmt_reg),
        .vlim(vlim),
        .hlim(hlim)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Saturate a signed value into +-lim.
    function automatic logic signed [21:0] sat(input logic signed [21:0] v,
                                               input logic [19:0] lim);
        logic signed [21:0] l;
        l = signed'({2'b00, lim});
        if (v > l)
            sat = l;
        else if (v < -l)
            sat = -l;
        else
            sat = v;
    endfunction

    // Clamp an insertion line into a window.
    function automatic logic [4:0] line_fit(input logic [4:0] v, input logic [4:0] lo,
                                            input logic [4:0] hi);
        if (v < lo)
            line_fit = lo;
        else if (v > hi)
            line_fit = hi;
        else
            line_fit = v;
    endfunction

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire wr_ctrl = reg_wr && (reg_addr == BROVI_ADDR_CTRL);
    wire wr_vert = reg_wr && (reg_addr == BROVI_ADDR_VERT);
    wire wr_coarse = reg_wr && (reg_addr == BROVI_ADDR_COARSE);
    wire wr_fine = reg_wr && (reg_addr == BROVI_ADDR_FINE);
    wire wr_tc = reg_wr && (reg_addr == BROVI_ADDR_TC_CFG);
    wire wr_tcofs = reg_wr && (reg_addr == BROVI_ADDR_TC_OFS);
    wire wr_step = reg_wr && (reg_addr == BROVI_ADDR_STEP);
    wire zero_req = wr_ctrl && reg_wdata[BROVI_CTRL_ZERO_BIT];
    wire is_525 = (fmt_reg == BROVI_FMT_525);
    wire is_sd = is_525 || (fmt_reg == BROVI_FMT_625);
    wire [4:0] lmin = is_525 ? BROVI_L525_MIN : BROVI_L625_MIN;
    wire [4:0] lmax = is_525 ? BROVI_L525_MAX : BROVI_L625_MAX;
    wire [4:0] fmax = is_525 ? BROVI_TC_F30MAX : BROVI_TC_F25MAX;

    // Signed adjustments are written as deltas and added unscaled; the step-size
    // register is only stored, for software's format-dependent increments.
    wire signed [21:0] vert_sum = 22'(vert_reg) + 22'(signed'(reg_wdata[11:0]));
    wire signed [21:0] coarse_sum = 22'(coarse_reg) + 22'(signed'(reg_wdata[20:0]));
    wire signed [21:0] fine_sum = 22'(fine_reg) + 22'(signed'(reg_wdata[12:0]));
    wire signed [21:0] vert_next = sat(wr_vert ? vert_sum : 22'(vert_reg),
                                       {9'h000, vlim});
    wire signed [21:0] coarse_next = sat(wr_coarse ? coarse_sum : 22'(coarse_reg),
                                         hlim);
    wire signed [21:0] fine_next = sat(wr_fine ? fine_sum : 22'(fine_reg),
                                       {8'h00, BROVI_FLIM});

    // Timecode offset fields are limited to a legal time of day.
    wire [4:0] ofs_h = reg_wdata[22:18] > BROVI_TC_HMAX ? BROVI_TC_HMAX : reg_wdata[22:18];
    wire [5:0] ofs_m = reg_wdata[17:12] > BROVI_TC_MSMAX ? BROVI_TC_MSMAX : reg_wdata[17:12];
    wire [5:0] ofs_s = reg_wdata[11:6] > BROVI_TC_MSMAX ? BROVI_TC_MSMAX : reg_wdata[11:6];
    wire [4:0] ofs_f = reg_wdata[4:0] > fmax ? fmax : reg_wdata[4:0];

    // ----------------------------------------------------------------
    // Offset registers
    // ----------------------------------------------------------------
    // Offsets are re-saturated every cycle, so a format change clamps them.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || zero_req)
        begin
            vert_reg <= '0;
            coarse_reg <= '0;
            fine_reg <= '0;
        end
        else
        begin
            vert_reg <= vert_next[11:0];
            coarse_reg <= coarse_next[20:0];
            fine_reg <= fine_next[12:0];
        end
    end

    // Format and step sizes; steps are software's per-format increments.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fmt_reg <= BROVI_FMT_525;
            coarse_step_reg <= '0;
            fine_step_reg <= '0;
        end
        else
        begin
            if (wr_ctrl && (reg_wdata[3:0] <= 4'(BROVI_FMT_720_50)))
                fmt_reg <= brovi_fmt_e'(reg_wdata[3:0]);
            if (wr_step)
            begin
                coarse_step_reg <= reg_wdata[15:0];
                fine_step_reg <= reg_wdata[31:BROVI_STEP_FINE_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // Timecode configuration
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            src_reg <= BROVI_SRC_DISABLED;
            drop_reg <= 1'b1;
            s1_en_reg <= 1'b0;
            s2_en_reg <= 1'b0;
            l1_reg <= BROVI_L1_RST;
            l2_reg <= BROVI_L2_RST;
            tc_neg_reg <= 1'b0;
            tc_ofs_reg <= '0;
        end
        else
        begin
            if (wr_tc)
            begin
                if (reg_wdata[BROVI_TC_SRC_LSB +: 3] <= BROVI_SRC_PROGRAM)
                    src_reg <= reg_wdata[BROVI_TC_SRC_LSB +: 3];
                drop_reg <= reg_wdata[BROVI_TC_DROP_BIT];
                s1_en_reg <= reg_wdata[BROVI_TC_S1EN_BIT];
                s2_en_reg <= reg_wdata[BROVI_TC_S2EN_BIT];
                l1_reg <= line_fit(reg_wdata[BROVI_TC_L1_LSB +: 5], lmin, lmax);
                l2_reg <= line_fit(reg_wdata[BROVI_TC_L2_LSB +: 5], lmin, lmax);
            end
            else
            begin
                l1_reg <= line_fit(l1_reg, lmin, lmax);
                l2_reg <= line_fit(l2_reg, lmin, lmax);
            end
            if (wr_tcofs)
            begin
                tc_neg_reg <= reg_wdata[31];
                tc_ofs_reg <= {ofs_h, ofs_m, ofs_s, 1'b0, ofs_f};
            end
        end
    end

    // ----------------------------------------------------------------
    // Timecode source selection and insertion gating
    // ----------------------------------------------------------------
    logic [31:0] src_word;
    always_comb
    begin
        unique case (src_reg)
            BROVI_SRC_LOCAL_TIME_WITH_DAYLIGHT: src_word = src_tc_local_time_with_daylight;
            BROVI_SRC_LOCAL_TIME_NO_DAYLIGHT: src_word = src_tc_local;
            BROVI_SRC_UTC: src_word = src_tc_utc;
            BROVI_SRC_PROGRAM: src_word = src_tc_program;
            default: src_word = '0;
        endcase
    end

    // The offset is only held for read-back; no output carries it, and
    // vitc_word is the selected source word unchanged.
    wire src_on = (src_reg != BROVI_SRC_DISABLED);
    wire hit1 = s1_en_reg && (ref_line == l1_reg);
    wire hit2 = s2_en_reg && (ref_line == l2_reg);
    wire ins_ok = is_sd && src_on;
    wire tc_on = ins_ok && (s1_en_reg || s2_en_reg);

    // Outputs, all registered; offsets follow the internal reference only.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            vert_ofs <= '0;
            coarse_ofs <= '0;
            fine_ofs <= '0;
            timecode_slot_one <= 1'b0;
            timecode_slot_two <= 1'b0;
            vitc_active <= 1'b0;
            vitc_word <= '0;
            drop_frame <= 1'b0;
        end
        else
        begin
            vert_ofs <= vert_reg;
            coarse_ofs <= coarse_reg;
            fine_ofs <= fine_reg;
            timecode_slot_one <= ins_ok && hit1 && ref_line_start;
            timecode_slot_two <= ins_ok && hit2 && ref_line_start;
            vitc_active <= tc_on;
            vitc_word <= tc_on ? src_word : '0;
            drop_frame <= is_525 && drop_reg;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            BROVI_ADDR_CTRL: rd_mux = {28'h0000000, fmt_reg};
            BROVI_ADDR_VERT: rd_mux = 32'(vert_reg);
            BROVI_ADDR_COARSE: rd_mux = 32'(coarse_reg);
            BROVI_ADDR_FINE: rd_mux = 32'(fine_reg);
            BROVI_ADDR_TC_CFG: rd_mux = {11'h000, l2_reg, 3'h0, l1_reg, 1'b0, src_reg,
                                          1'b0, s2_en_reg, s1_en_reg, drop_reg};
            BROVI_ADDR_TC_OFS: rd_mux = {tc_neg_reg, 8'h00, tc_ofs_reg};
            BROVI_ADDR_STEP: rd_mux = {fine_step_reg, coarse_step_reg};
            BROVI_ADDR_LTC_MEAS: rd_mux = {12'h000, ltc_meas};
            BROVI_ADDR_STATUS: rd_mux = {29'h0, vitc_active, is_525, is_sd};
            BROVI_ADDR_TC_SRC: rd_mux = src_word;
            default: rd_mux = '0;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rd_mux;
        else
            reg_rdata <= '0;
    end

endmodule
`default_nettype wire

//--- tb/brovi_top_monitor.sv
// Checker of offsets, read-back and timecode pulses at the top ports.
`timescale 1ns/1ps
`default_nettype none
module brovi_top_monitor
    import brovi_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic ref_line_start,
    input wire logic [19:0] ltc_meas,
    input wire logic [31:0] reg_rdata,
    input wire logic signed [11:0] vert_ofs,
    input wire logic signed [20:0] coarse_ofs,
    input wire logic signed [12:0] fine_ofs,
    input wire logic timecode_slot_one,
    input wire logic timecode_slot_two,
    input wire logic vitc_active,
    input wire logic [31:0] vitc_word
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // One clock domain, so clocking and reset are given once for all.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence zero_req;
        reg_wr && reg_addr == BROVI_ADDR_CTRL && reg_wdata[BROVI_CTRL_ZERO_BIT];
    endsequence
    sequence vert_read;
        reg_rd && reg_addr == BROVI_ADDR_VERT;
    endsequence

    // Register stage then output stage, so the cleared offsets show two edges later.
    zero_offsets_a: assert property (
        zero_req |-> ##2 (vert_ofs == 0 && coarse_ofs == 0 && fine_ofs == 0))
        else $error("offsets not cleared by zero request");
    fine_range_a: assert property (fine_ofs <= 13'sh3E8 && fine_ofs >= -13'sh3E8)
        else $error("fine offset beyond its span");
    vert_range_a: assert property (vert_ofs <= 12'sh4E2 && vert_ofs >= -12'sh4E2)
        else $error("vertical offset beyond widest span");
    vert_read_a: assert property (
        vert_read |=> reg_rdata == {{20{vert_ofs[11]}}, vert_ofs})
        else $error("vertical read-back differs from output");
    ltc_read_a: assert property (
        reg_rd && reg_addr == BROVI_ADDR_LTC_MEAS |=> reg_rdata[19:0] == $past(ltc_meas))
        else $error("measured timing not reported");
    slot_one_cause_a: assert property (timecode_slot_one |-> $past(ref_line_start))
        else $error("slot one pulse without a line start");
    slot_two_pulse_a: assert property (timecode_slot_two |=> !timecode_slot_two)
        else $error("slot two pulse longer than one cycle");
    idle_word_a: assert property (!vitc_active |-> vitc_word == 32'h0)
        else $error("timecode word present while insertion is off");
endmodule

bind brovi_top brovi_top_monitor #(.ADDR_W(ADDR_W)) mon (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .ref_line_start(ref_line_start), .ltc_meas(ltc_meas),
    .reg_rdata(reg_rdata), .vert_ofs(vert_ofs), .coarse_ofs(coarse_ofs), .fine_ofs(fine_ofs),
    .timecode_slot_one(timecode_slot_one), .timecode_slot_two(timecode_slot_two),
    .vitc_active(vitc_active), .vitc_word(vitc_word));
`default_nettype wire

//--- tb/brovi_ref_model.sv
// Model of the internal line reference and of the equipment fed by slot pulses.
`timescale 1ns/1ps
`default_nettype none
module brovi_ref_model
#(
    parameter int GAP = 4,
    parameter int LINES = 26
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic timecode_slot_one,
    input wire logic timecode_slot_two,
    output logic [4:0] ref_line,
    output logic ref_line_start,
    output int hits_one,
    output logic [4:0] last_one,
    output logic [4:0] last_two
);
    int gap_cnt;

    // ----------------------------------------------------------------
    // Reference and receiver
    // ----------------------------------------------------------------
    // Starts are GAP cycles apart so no slot pulse ever abuts the next start.
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            gap_cnt <= 0;
            ref_line <= 5'h0;
            ref_line_start <= 1'b0;
        end
        else
        begin
            gap_cnt <= (gap_cnt == GAP - 1) ? 0 : gap_cnt + 1;
            ref_line_start <= (gap_cnt == 0);
            if (gap_cnt == 0)
                ref_line <= (ref_line == 5'(LINES - 1)) ? 5'h0 : ref_line + 5'h1;
        end
    end

    // The line still stands when a pulse arrives, so it names the carrying line.
    always @(posedge core_clk)
    begin
        if (sys_rst)
            hits_one <= 0;
        else if (timecode_slot_one)
            hits_one <= hits_one + 1;
        if (timecode_slot_one)
            last_one <= ref_line;
        if (timecode_slot_two)
            last_two <= ref_line;
    end
endmodule
`default_nettype wire

//--- tb/black_ref_offset_vitc_insert_bench.sv
// Self-checking bench for the reference offset and timecode block.
`timescale 1ns/1ps
`default_nettype none
module black_ref_offset_vitc_insert_bench
    import brovi_pkg::*;
;
    typedef struct packed {logic [3:0] wa; logic [31:0] wd; logic [3:0] ra; logic [31:0] ex;} brovi_row_s;
    logic core_clk, sys_rst, reg_wr, reg_rd, ref_line_start;
    logic slot_one, slot_two, vitc_active, drop_frame;
    logic [3:0] reg_addr;
    logic [4:0] ref_line, last_one, last_two;
    logic [31:0] reg_wdata, reg_rdata, vitc_word, q;
    logic signed [11:0] vert_ofs;
    int hits_one, h;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] srcs [4] = '{32'h01020304, 32'h05060708, 32'h090A0B0C, 32'h0D0E0F10};
    // Rows run in order; every write except those to 4'h7, 4'h8 and 4'hF leaves state for later rows.
    brovi_row_s rows [22] = '{
        '{4'h1, 32'h000001F4, 4'h1, 32'h000001F4},
        '{4'h1, 32'h00000064, 4'h1, 32'h0000020D},
        '{4'h1, 32'h00000FFF, 4'h1, 32'h0000020C},
        '{4'h3, 32'h000004B0, 4'h3, 32'h000003E8},
        '{4'h2, 32'h000AAE60, 4'h2, 32'h0009B2A4},
        '{4'h0, 32'h00000001, 4'h2, 32'h0009B2A4},
        '{4'h1, 32'h000007D0, 4'h1, 32'h000004E2},
        '{4'h0, 32'h00000007, 4'h1, 32'h00000177},
        '{4'h0, 32'h00000007, 4'h2, 32'h0003640E},
        '{4'h0, 32'h00000006, 4'h1, 32'h00000177},
        '{4'h2, 32'h000AAE60, 4'h2, 32'h0005A835},
        '{4'h0, 32'h00000100, 4'h3, 32'h00000000},
        '{4'h5, 32'h802FBEDD, 4'h5, 32'h802FBEDD},
        '{4'h4, 32'h00031911, 4'h4, 32'h000A1411},
        '{4'h4, 32'h00031971, 4'h4, 32'h000A1411},
        '{4'h0, 32'h00000001, 4'h4, 32'h000A1411},
        '{4'h4, 32'h00170511, 4'h4, 32'h00160611},
        '{4'h0, 32'h00000000, 4'h4, 32'h00140A11},
        '{4'h6, 32'h12345678, 4'h6, 32'h12345678},
        '{4'h8, 32'h00000000, 4'h8, 32'h00000003},
        '{4'hF, 32'hFFFFFFFF, 4'hF, 32'h00000000},
        '{4'h7, 32'h00000000, 4'h7, 32'h000ABCDE}};

    brovi_top dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .ref_line(ref_line), .ref_line_start(ref_line_start),
        .src_tc_local_time_with_daylight(srcs[0]), .src_tc_local(srcs[1]), .src_tc_utc(srcs[2]),
        .src_tc_program(srcs[3]), .ltc_meas(20'hABCDE), .reg_rdata(reg_rdata),
        .vert_ofs(vert_ofs), .coarse_ofs(), .fine_ofs(), .timecode_slot_one(slot_one),
        .timecode_slot_two(slot_two), .vitc_active(vitc_active), .vitc_word(vitc_word),
        .drop_frame(drop_frame));
    brovi_ref_model far (
        .core_clk(core_clk), .sys_rst(sys_rst), .timecode_slot_one(slot_one),
        .timecode_slot_two(slot_two), .ref_line(ref_line), .ref_line_start(ref_line_start),
        .hits_one(hits_one), .last_one(last_one), .last_two(last_two));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // One bus cycle; three idle edges let the one-cycle format lag settle.
    task automatic acc(input logic [3:0] a, input logic [31:0] d, input logic w,
                       output logic [31:0] rq);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rq = reg_rdata;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        num_errors += (seen !== exp);
    endtask

    task automatic results();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge core_clk);
        check({31'h0, vitc_active}, 32'h0);
        sys_rst <= 1'b0;
        acc(BROVI_ADDR_TC_CFG, 32'h0, 1'b0, q);
        check(q, 32'h00100E01);
        check({31'h0, drop_frame}, 32'h1);
        foreach (rows[i])
        begin
            acc(rows[i].wa, rows[i].wd, 1'b1, q);
            acc(rows[i].ra, 32'h0, 1'b0, q);
            check(q, rows[i].ex);
        end
        // Both slots on lines 14 and 16, fed from universal time.
        acc(BROVI_ADDR_TC_CFG, 32'h00100E37, 1'b1, q);
        for (int k = 0; k < 400 && hits_one < 2; k++)
            @(negedge core_clk);
        check(hits_one, 32'h2);
        check(last_one, 32'hE);
        check(last_two, 32'h10);
        check(vitc_word, srcs[2]);
        for (int s = 1; s < 5; s++)
        begin
            acc(BROVI_ADDR_TC_CFG, 32'h00100E06 | (s << 4) | (s & 1), 1'b1, q);
            check(vitc_word, srcs[s - 1]);
            check({31'h0, drop_frame}, 32'(s & 1));
        end
        // A high-definition format must silence insertion entirely.
        acc(BROVI_ADDR_CTRL, 32'h00000002, 1'b1, q);
        h = hits_one;
        repeat (120) @(negedge core_clk);
        check(hits_one, h);
        check({vitc_active, drop_frame}, 32'h0);
        acc(BROVI_ADDR_VERT, 32'h00000005, 1'b1, q);
        @(posedge core_clk) sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        check({20'h0, vert_ofs}, 32'h0);
        acc(BROVI_ADDR_TC_CFG, 32'h0, 1'b0, q);
        check(q, 32'h00100E01);
        results();
    end
endmodule
`default_nettype wire
